// >>> verilog/aaf_pkg.sv
//------------------------------------------------------------------------------
// Functional notes
// RULE_01: Mode 000: no accumulation, test, done flag.
// RULE_02: Mode 001: add term, count, done flag.
// RULE_03: Accumulate: load shifted output, test every sample.
// RULE_04: Mode 010: accumulate; test when count reaches target.
// RULE_05: Average: clear at trigger once target reached.
// RULE_06: Burst: clear on trigger, retrigger until target.
// RULE_07: Filter: term plus acc minus shifted acc.
// RULE_08: Counter increments per cycle, saturates at FF.
// RULE_09: Double sampling: term is current minus previous.
// RULE_10: 16-bit accumulator, overflow flag above 65535.
// RULE_11: Clear bit clears acc, overflow, counter, itself.
// RULE_12: Clearing takes five oscillator cycles.
// RULE_13: Filter output is accumulator shifted right.
// RULE_14: Accumulator stays right-justified always.
// RULE_15: Every trigger, go or external, starts conversion; the code ignores triggers unless idle with the clear bit low.
// RULE_16: Software clears accumulator after target reached.
// RULE_17: Threshold condition met sets threshold hit flag.
// RULE_18: Basic mode leaves accumulator and counter unchanged.
//------------------------------------------------------------------------------
package aaf_pkg;
    // Widths
    localparam int RES_W = 10;
    localparam int ACC_W = 16;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_REPEAT = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_ACC = 8'h0C;
    localparam logic [7:0] OFS_FILTER = 8'h10;
    localparam logic [7:0] OFS_PREV = 8'h14;

    // Control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DSE_BIT = 3;
    localparam int CTRL_SHIFT_LSB = 4;
    localparam int CTRL_CLR_BIT = 7;
    localparam int CTRL_GO_BIT = 8;

    // Status field positions
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_HIT_BIT = 1;
    localparam int STAT_OVF_BIT = 2;
    localparam int STAT_CNT_LSB = 8;

    // Reset values
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [2:0] SHIFT_RST = 3'h0;
    localparam logic [CNT_W-1:0] REPEAT_RST = 8'h00;

    // Clearing time in oscillator cycles
    localparam int CLEAR_CYCLES = 5;
    localparam logic [2:0] CLEAR_LAST = 3'(CLEAR_CYCLES - 1);

    // Compute modes
    typedef enum logic [2:0] {
        MD_BASIC = 3'h0,
        MD_ACCUM = 3'h1,
        MD_AVG = 3'h2,
        MD_BURST = 3'h3,
        MD_LPF = 3'h4
    } aaf_mode_t;

    // Sequencer states, two-bit codes with code 2 unused
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CONV = 2'h1,
        ST_CLEAR = 2'h3
    } aaf_state_t;
endpackage

// >>> verilog/aaf_sat_cnt.sv
`timescale 1ns/10ps
module aaf_sat_cnt (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic clr,
    input wire logic inc,
    // Count
    output logic [aaf_pkg::CNT_W-1:0] cnt,
    output logic [aaf_pkg::CNT_W-1:0] cnt_plus
);
    import aaf_pkg::*;

    // Saturating successor
    assign cnt_plus = (cnt == CNT_MAX) ? cnt : cnt + 8'h01; // RULE_08

    // Count register, clear wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= 8'h00;
        end else if (clr) begin
            cnt <= 8'h00;
        end else if (inc) begin
            cnt <= cnt_plus; // RULE_08
        end
    end
endmodule

// >>> verilog/aaf_top.sv
`timescale 1ns/10ps
module aaf_top (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RSTN,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Converter core
    input wire logic EXT_TRIG,
    output logic CONV_START_O,
    input wire logic RESULT_VALID_I,
    input wire logic [aaf_pkg::RES_W-1:0] RESULT_I,
    // Threshold logic
    output logic THRESH_TEST_O,
    input wire logic THRESH_MET_I,
    output logic [aaf_pkg::ACC_W-1:0] FILTER_OUT_O
);
    import aaf_pkg::*;

    //--------------------------------------------------------------------------
    // Declarations
    //--------------------------------------------------------------------------
    aaf_state_t state_reg;
    logic [2:0] mode_reg;
    logic dse_reg;
    logic [2:0] shift_reg;
    logic clr_bit_reg;
    logic [CNT_W-1:0] repeat_reg;
    logic done_flag_reg;
    logic hit_flag_reg;
    logic ovf_reg;
    logic [ACC_W-1:0] acc_reg;
    logic [ACC_W-1:0] filt_reg;
    logic [RES_W-1:0] prev_reg;
    logic phase_reg;
    logic retrig_reg;
    logic test_reg;
    logic start_reg;
    logic [2:0] clr_cnt_reg;
    logic ext_meta_reg;
    logic ext_sync_reg;
    logic ext_prev_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] cnt_plus;
    logic wr_en;
    logic go_pulse;
    logic ext_rise;
    logic start;
    logic trig_clear;
    logic conv_ev;
    logic ds_first;
    logic cycle_done;
    logic accum_mode;
    logic acc_upd;
    logic clr_fin;
    logic signed [RES_W:0] term;
    logic [ACC_W-1:0] acc_shift;
    logic [ACC_W+1:0] sum;
    logic sum_ovf;
    logic [ACC_W-1:0] acc_next;
    logic reached_next;
    logic [31:0] rd_data;

    //--------------------------------------------------------------------------
    // Wishbone slave
    //--------------------------------------------------------------------------
    // One wait state, write commits on the ack edge
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= WB_CYC_I & WB_STB_I & ~ack_reg;
        end
    end

    assign wr_en = WB_CYC_I & WB_STB_I & WB_WE_I & ack_reg;
    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = dat_reg;

    // Read mux, unmapped reads as zero
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (WB_ADR_I)
            OFS_CTRL: begin
                rd_data[CTRL_MODE_LSB +: 3] = mode_reg;
                rd_data[CTRL_DSE_BIT] = dse_reg;
                rd_data[CTRL_SHIFT_LSB +: 3] = shift_reg;
                rd_data[CTRL_CLR_BIT] = clr_bit_reg;
                rd_data[CTRL_GO_BIT] = (state_reg == ST_CONV);
            end
            OFS_REPEAT: rd_data[CNT_W-1:0] = repeat_reg;
            OFS_STATUS: begin
                rd_data[STAT_DONE_BIT] = done_flag_reg;
                rd_data[STAT_HIT_BIT] = hit_flag_reg;
                rd_data[STAT_OVF_BIT] = ovf_reg;
                rd_data[STAT_CNT_LSB +: CNT_W] = cnt;
            end
            OFS_ACC: rd_data[ACC_W-1:0] = acc_reg;
            OFS_FILTER: rd_data[ACC_W-1:0] = filt_reg;
            OFS_PREV: rd_data[RES_W-1:0] = prev_reg;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // Read data captured ahead of the ack
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            dat_reg <= 32'h0000_0000;
        end else if (WB_CYC_I & WB_STB_I & ~ack_reg) begin
            dat_reg <= rd_data;
        end
    end

    // Control fields
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            mode_reg <= MODE_RST;
            dse_reg <= 1'b0;
            shift_reg <= SHIFT_RST;
            repeat_reg <= REPEAT_RST;
        end else if (wr_en & WB_SEL_I[0]) begin
            if (WB_ADR_I == OFS_CTRL) begin
                mode_reg <= WB_DAT_I[CTRL_MODE_LSB +: 3];
                dse_reg <= WB_DAT_I[CTRL_DSE_BIT];
                shift_reg <= WB_DAT_I[CTRL_SHIFT_LSB +: 3];
            end
            if (WB_ADR_I == OFS_REPEAT) begin
                repeat_reg <= WB_DAT_I[CNT_W-1:0];
            end
        end
    end

    assign go_pulse = wr_en & WB_SEL_I[1] & (WB_ADR_I == OFS_CTRL) & WB_DAT_I[CTRL_GO_BIT];

    // Clear bit, software set wins over hardware clear
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            clr_bit_reg <= 1'b0;
        end else if (wr_en & WB_SEL_I[0] & (WB_ADR_I == OFS_CTRL) & WB_DAT_I[CTRL_CLR_BIT]) begin
            clr_bit_reg <= 1'b1;
        end else if (clr_fin) begin
            clr_bit_reg <= 1'b0; // RULE_11
        end
    end

    //--------------------------------------------------------------------------
    // Trigger sources
    //--------------------------------------------------------------------------
    // External trigger synchroniser and edge detect
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            ext_meta_reg <= EXT_TRIG;
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
        end
    end

    assign ext_rise = ext_sync_reg & ~ext_prev_reg;
    assign start = (state_reg == ST_IDLE) & ~clr_bit_reg
                   & (go_pulse | ext_rise | retrig_reg); // RULE_15
    // Burst clears on a fresh trigger only, never on its own retrigger
    assign trig_clear = start & (((mode_reg == MD_AVG) & (cnt >= repeat_reg)) // RULE_05
                                 | ((mode_reg == MD_BURST) & ~retrig_reg)); // RULE_06

    //--------------------------------------------------------------------------
    // Sequencer
    //--------------------------------------------------------------------------
    // Idle, converting, clearing
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            state_reg <= ST_IDLE;
            clr_cnt_reg <= 3'h0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    clr_cnt_reg <= 3'h0;
                    if (start) begin
                        state_reg <= ST_CONV;
                    end else if (clr_bit_reg) begin
                        state_reg <= ST_CLEAR;
                    end
                end
                ST_CONV: begin
                    if (RESULT_VALID_I) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_CLEAR: begin
                    clr_cnt_reg <= clr_cnt_reg + 3'h1;
                    if (clr_fin) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign clr_fin = (state_reg == ST_CLEAR) & (clr_cnt_reg == CLEAR_LAST); // RULE_12

    // Conversion start strobe
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            start_reg <= 1'b0;
        end else begin
            start_reg <= start; // RULE_15
        end
    end

    assign CONV_START_O = start_reg;

    //--------------------------------------------------------------------------
    // Sample term and accumulator math
    //--------------------------------------------------------------------------
    assign conv_ev = (state_reg == ST_CONV) & RESULT_VALID_I;
    assign ds_first = dse_reg & ~phase_reg;
    assign cycle_done = conv_ev & ~ds_first; // RULE_09
    assign accum_mode = (mode_reg >= MD_ACCUM) & (mode_reg <= MD_LPF);
    assign acc_upd = cycle_done & accum_mode; // RULE_18

    // Right-justified raw result, difference when double sampling
    assign term = dse_reg ? $signed({1'b0, RESULT_I}) - $signed({1'b0, prev_reg})
                          : $signed({1'b0, RESULT_I}); // RULE_09 RULE_14

    assign acc_shift = acc_reg >> shift_reg; // RULE_13
    assign sum = {2'b00, acc_reg} + {{(ACC_W+1-RES_W){term[RES_W]}}, term}
                 - ((mode_reg == MD_LPF) ? {2'b00, acc_shift} : 18'h00000); // RULE_07
    assign sum_ovf = ~sum[ACC_W+1] & sum[ACC_W]; // RULE_10
    assign acc_next = sum[ACC_W-1:0];
    assign reached_next = cnt_plus >= repeat_reg;

    // Double-sample phase and previous result
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            phase_reg <= 1'b0;
            prev_reg <= 10'h000;
        end else if (conv_ev) begin
            phase_reg <= dse_reg & ~phase_reg;
            prev_reg <= RESULT_I;
        end else if (~dse_reg) begin
            phase_reg <= 1'b0;
        end
    end

    // Accumulator
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            acc_reg <= 16'h0000;
        end else if (clr_fin | trig_clear) begin
            acc_reg <= 16'h0000; // RULE_11
        end else if (acc_upd) begin
            acc_reg <= acc_next; // RULE_02
        end
    end

    // Overflow flag, set wins over clear
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            ovf_reg <= 1'b0;
        end else if (acc_upd & sum_ovf) begin
            ovf_reg <= 1'b1; // RULE_10
        end else if (clr_fin) begin
            ovf_reg <= 1'b0; // RULE_11
        end
    end

    // Filter output from the new accumulator
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            filt_reg <= 16'h0000;
        end else if (acc_upd) begin
            filt_reg <= acc_next >> shift_reg; // RULE_03 RULE_13
        end
    end

    assign FILTER_OUT_O = filt_reg;

    // Sample counter
    aaf_sat_cnt u_cnt (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .clr(clr_fin | trig_clear),
        .inc(acc_upd),
        .cnt(cnt),
        .cnt_plus(cnt_plus)
    );

    //--------------------------------------------------------------------------
    // Threshold test, retrigger and flags
    //--------------------------------------------------------------------------
    // Test strobe per mode
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            test_reg <= 1'b0;
        end else begin
            test_reg <= cycle_done & (~accum_mode | (mode_reg == MD_ACCUM) // RULE_01 RULE_03
                                      | reached_next); // RULE_04 RULE_07
        end
    end

    assign THRESH_TEST_O = test_reg;

    // Burst retrigger until the target count
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            retrig_reg <= 1'b0;
        end else begin
            retrig_reg <= conv_ev & (mode_reg == MD_BURST) & (ds_first | ~reached_next); // RULE_06
        end
    end

    // Sticky flags, write one to clear, set wins
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            done_flag_reg <= 1'b0;
            hit_flag_reg <= 1'b0;
        end else begin
            if (conv_ev) begin
                done_flag_reg <= 1'b1; // RULE_01 RULE_02
            end else if (wr_en & WB_SEL_I[0] & (WB_ADR_I == OFS_STATUS)
                         & WB_DAT_I[STAT_DONE_BIT]) begin
                done_flag_reg <= 1'b0;
            end
            if (test_reg & (THRESH_MET_I | ovf_reg)) begin
                hit_flag_reg <= 1'b1; // RULE_17
            end else if (wr_en & WB_SEL_I[0] & (WB_ADR_I == OFS_STATUS)
                         & WB_DAT_I[STAT_HIT_BIT]) begin
                hit_flag_reg <= 1'b0;
            end
        end
    end

    //--------------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------------
    property p_done_flag;
        @(posedge REF_CLK) disable iff (!RSTN) conv_ev |=> done_flag_reg;
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("done flag not set"); // RULE_01

    property p_basic_hold;
        @(posedge REF_CLK) disable iff (!RSTN)
            (cycle_done && mode_reg == MD_BASIC) |=> $stable(acc_reg) && $stable(cnt);
    endproperty
    a_basic_hold: assert property (p_basic_hold) else $error("basic mode changed acc"); // RULE_18

    property p_cnt_inc;
        @(posedge REF_CLK) disable iff (!RSTN)
            (acc_upd && !clr_fin && cnt != CNT_MAX) |=> cnt == $past(cnt) + 8'h01;
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("counter did not increment"); // RULE_02

    property p_cnt_sat;
        @(posedge REF_CLK) disable iff (!RSTN)
            (acc_upd && !clr_fin && cnt == CNT_MAX) |=> cnt == CNT_MAX;
    endproperty
    a_cnt_sat: assert property (p_cnt_sat) else $error("counter wrapped"); // RULE_08

    property p_filter;
        @(posedge REF_CLK) disable iff (!RSTN)
            (acc_upd && !clr_fin) |=> filt_reg == (acc_reg >> $past(shift_reg));
    endproperty
    a_filter: assert property (p_filter) else $error("filter output mismatch"); // RULE_13

    property p_clear_len;
        @(posedge REF_CLK) disable iff (!RSTN)
            $rose(state_reg == ST_CLEAR) |-> !clr_fin [*4] ##1 clr_fin;
    endproperty
    a_clear_len: assert property (p_clear_len) else $error("clear length wrong"); // RULE_12

    property p_clear_res;
        @(posedge REF_CLK) disable iff (!RSTN)
            (clr_fin && !wr_en) |=> acc_reg == 16'h0000 && cnt == 8'h00
                                    && !ovf_reg && !clr_bit_reg;
    endproperty
    a_clear_res: assert property (p_clear_res) else $error("clear incomplete"); // RULE_11

    property p_burst_clr;
        @(posedge REF_CLK) disable iff (!RSTN)
            (start && !retrig_reg && mode_reg == MD_BURST) |=> acc_reg == 16'h0000 && cnt == 8'h00;
    endproperty
    a_burst_clr: assert property (p_burst_clr) else $error("burst did not clear"); // RULE_06

    property p_avg_test;
        @(posedge REF_CLK) disable iff (!RSTN)
            (cycle_done && mode_reg == MD_AVG) |=> THRESH_TEST_O == $past(reached_next);
    endproperty
    a_avg_test: assert property (p_avg_test) else $error("average test timing wrong"); // RULE_04

    property p_ovf;
        @(posedge REF_CLK) disable iff (!RSTN) (acc_upd && sum_ovf) |=> ovf_reg;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged"); // RULE_10

    property p_start;
        @(posedge REF_CLK) disable iff (!RSTN) go_pulse && state_reg == ST_IDLE && !clr_bit_reg
            |=> CONV_START_O ##1 !CONV_START_O;
    endproperty
    a_start: assert property (p_start) else $error("go did not start conversion"); // RULE_15

    c_burst_end: cover property (@(posedge REF_CLK) disable iff (!RSTN)
        THRESH_TEST_O && mode_reg == MD_BURST);
    c_lpf_test: cover property (@(posedge REF_CLK) disable iff (!RSTN)
        THRESH_TEST_O && mode_reg == MD_LPF);
    c_clear: cover property (@(posedge REF_CLK) disable iff (!RSTN) clr_fin);
    c_hit: cover property (@(posedge REF_CLK) disable iff (!RSTN) $rose(hit_flag_reg));
endmodule

// >>> tb/aaf_conv_model.sv
`timescale 1ns/10ps
module aaf_conv_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request, value to give and latency
    input wire logic start,
    input wire logic [aaf_pkg::RES_W-1:0] sample,
    input wire logic [3:0] lat,
    // Answer
    output logic valid,
    output logic [aaf_pkg::RES_W-1:0] result
);
    import aaf_pkg::*;

    logic [3:0] wait_reg;
    logic busy_reg;

    // One conversion outstanding; result bus toggles when not valid
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
            wait_reg <= 4'h0;
            valid <= 1'b0;
            result <= 10'h000;
        end else if (start) begin
            busy_reg <= 1'b1;
            wait_reg <= lat;
            valid <= 1'b0;
            result <= ~result;
        end else if (busy_reg && wait_reg == 4'h0) begin
            busy_reg <= 1'b0;
            valid <= 1'b1;
            result <= sample;
        end else begin
            if (busy_reg) begin
                wait_reg <= wait_reg - 4'h1;
            end
            valid <= 1'b0;
            result <= ~result;
        end
    end
endmodule

// >>> tb/tb.sv
`timescale 1ns/10ps
module tb;
    import aaf_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic ext = 1'b0;
    logic met = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [9:0] smp = 10'h000;
    logic [3:0] lat = 4'h1;
    logic ack, cs, rv, tt;
    logic [31:0] rdat, rd;
    logic [9:0] res;
    logic [15:0] fout;
    int num_errors = 0;
    int compares = 0;
    int rv_cnt = 0;
    int tst_cnt = 0;
    int t0, base, n, i;
    logic [7:0] ctrl_q = 8'h00;

    aaf_top i_dut (.REF_CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .EXT_TRIG(ext), .CONV_START_O(cs), .RESULT_VALID_I(rv), .RESULT_I(res),
        .THRESH_TEST_O(tt), .THRESH_MET_I(met), .FILTER_OUT_O(fout));
    aaf_conv_model i_conv (.clk(clk), .rst_n(rstn), .start(cs), .sample(smp), .lat(lat),
        .valid(rv), .result(res));

    // Clock and event counters
    always #20 clk = ~clk;
    always @(posedge clk) begin
        if (rv === 1'b1) rv_cnt++;
        if (tt === 1'b1) tst_cnt++;
    end

    //--------------------------------------------------------------------------
    // Bus and check tasks
    //--------------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        if (k >= 50) num_errors++;
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Wait for a number of converter answers, then let flags settle
    task automatic wt(input int target);
        int k;
        k = 0;
        while (rv_cnt < target && k < 300) begin
            @(posedge clk);
            k++;
        end
        if (k >= 300) num_errors++;
        repeat (4) @(posedge clk);
    endtask

    task automatic conv(input logic [9:0] v, input int cnt);
        int b;
        b = rv_cnt;
        smp <= v;
        wb(1'b1, OFS_CTRL, {23'h0, 1'b1, ctrl_q});
        wt(b + cnt);
    endtask

    // Software clear of flags, accumulator and counter, with new control value
    task automatic setup(input logic [7:0] m);
        ctrl_q = m;
        wb(1'b1, OFS_STATUS, 32'h3);
        wb(1'b1, OFS_CTRL, {24'h0, m | 8'h80});
        wb(1'b0, OFS_CTRL, 32'h0);
        chk(rd & 32'h80, 32'h80);
        n = 0;
        while (rd[7] !== 1'b0 && n < 10) begin
            wb(1'b0, OFS_CTRL, 32'h0);
            n++;
        end
        rd_chk(OFS_ACC, 32'h0);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk(rd & 32'hFF07, 32'h0);
    endtask

    task automatic end_sim;
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        end_sim();
    end

    //--------------------------------------------------------------------------
    // Test sequence
    //--------------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd_chk(OFS_CTRL, 32'h0);
        rd_chk(OFS_STATUS, 32'h0);
        wb(1'b1, 8'h20, 32'hFFFFFFFF);
        rd_chk(8'h20, 32'h0);
        // Basic mode with threshold met
        met <= 1'b1;
        setup(8'h00);
        t0 = tst_cnt;
        conv(10'h007, 1);
        rd_chk(OFS_STATUS, 32'h3);
        rd_chk(OFS_ACC, 32'h0);
        chk(32'(tst_cnt - t0), 32'h1);
        // Spare mode code acts as basic
        setup(8'h05);
        conv(10'h007, 1);
        rd_chk(OFS_STATUS, 32'h3);
        rd_chk(OFS_ACC, 32'h0);
        met <= 1'b0;
        // Accumulate, shift 1, slow converter
        lat <= 4'h6;
        setup(8'h11);
        t0 = tst_cnt;
        conv(10'h064, 1);
        conv(10'h12C, 1);
        rd_chk(OFS_ACC, 32'h190);
        rd_chk(OFS_FILTER, 32'hC8);
        chk({16'h0, fout}, 32'hC8);
        rd_chk(OFS_STATUS, 32'h201);
        chk(32'(tst_cnt - t0), 32'h2);
        // Average, repeat 2
        lat <= 4'h1;
        wb(1'b1, OFS_REPEAT, 32'h2);
        setup(8'h02);
        t0 = tst_cnt;
        conv(10'h00A, 1);
        conv(10'h014, 1);
        rd_chk(OFS_ACC, 32'h1E);
        conv(10'h01E, 1);
        rd_chk(OFS_ACC, 32'h1E);
        chk(32'(tst_cnt - t0), 32'h1);
        // Burst, repeat 3, two triggers
        wb(1'b1, OFS_REPEAT, 32'h3);
        setup(8'h03);
        for (i = 0; i < 2; i++) begin
            t0 = tst_cnt;
            conv(10'h005, 3);
            rd_chk(OFS_ACC, 32'hF);
            wb(1'b0, OFS_STATUS, 32'h0);
            chk(rd & 32'hFF00, 32'h300);
            chk(32'(tst_cnt - t0), 32'h1);
        end
        // Low-pass filter, shift 1, repeat 2
        wb(1'b1, OFS_REPEAT, 32'h2);
        setup(8'h14);
        t0 = tst_cnt;
        conv(10'h064, 1);
        conv(10'h064, 1);
        rd_chk(OFS_ACC, 32'h96);
        conv(10'h064, 1);
        rd_chk(OFS_ACC, 32'hAF);
        chk({16'h0, fout}, 32'h57);
        chk(32'(tst_cnt - t0), 32'h2);
        // Double sampling in accumulate mode
        setup(8'h09);
        conv(10'h032, 1);
        conv(10'h050, 1);
        rd_chk(OFS_ACC, 32'h1E);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk(rd & 32'hFF00, 32'h100);
        rd_chk(OFS_PREV, 32'h50);
        // External trigger
        setup(8'h01);
        smp <= 10'h009;
        base = rv_cnt;
        ext <= 1'b1;
        repeat (3) @(posedge clk);
        ext <= 1'b0;
        wt(base + 1);
        rd_chk(OFS_ACC, 32'h9);
        // Counter saturation, then overflow
        setup(8'h01);
        for (i = 0; i < 257; i++) conv(10'h0FF, 1);
        rd_chk(OFS_ACC, 32'hFFFF);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk(rd & 32'hFF04, 32'hFF00);
        conv(10'h001, 1);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk(rd & 32'hFF06, 32'hFF06);
        end_sim();
    end
endmodule
